// File: pkg/fsc_pkg.sv
// Constants of the flash setting command decoder: opcodes, link steps, register map and reset values
package fsc_pkg;
    // Command opcodes
    localparam logic [7:0] OP_WRITE_ENABLE        = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE       = 8'h04;
    localparam logic [7:0] OP_READ_STATUS         = 8'h05;
    localparam logic [7:0] OP_READ_CONFIG         = 8'h15;
    localparam logic [7:0] OP_WRITE_STATUS_CONFIG = 8'h01;
    localparam logic [7:0] OP_READ_EXT_ADDR       = 8'hC8;
    localparam logic [7:0] OP_WRITE_EXT_ADDR      = 8'hC5;
    localparam logic [7:0] OP_ENTER_QUAD          = 8'h35;
    localparam logic [7:0] OP_EXIT_QUAD           = 8'hF5;
    localparam logic [7:0] OP_ENTER_WIDE_ADDR     = 8'hB7;
    localparam logic [7:0] OP_EXIT_WIDE_ADDR      = 8'hE9;
    localparam logic [7:0] OP_SUSPEND             = 8'hB0;
    localparam logic [7:0] OP_RESUME              = 8'h30;
    localparam logic [7:0] OP_DEEP_SLEEP          = 8'hB9;
    localparam logic [7:0] OP_WAKE_FROM_SLEEP     = 8'hAB;
    localparam logic [7:0] OP_BURST_LENGTH        = 8'hC0;

    // Link bits per clock and per byte, and data line output enables per mode
    localparam logic [2:0] SINGLE_STEP = 3'h1;
    localparam logic [2:0] QUAD_STEP   = 3'h4;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] OE_SINGLE   = 4'h2;
    localparam logic [3:0] OE_QUAD     = 4'hF;

    // Register byte offsets
    localparam logic [7:0] REG_FLAGS    = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CONFIG   = 8'h08;
    localparam logic [7:0] REG_EXT_ADDR = 8'h0C;
    localparam logic [7:0] REG_BURST    = 8'h10;
    localparam logic [7:0] REG_CTRL     = 8'h14;
    localparam logic [7:0] REG_LAST_OP  = 8'h18;

    // Field positions
    localparam int FLG_WEL   = 0;
    localparam int FLG_QUAD  = 1;
    localparam int FLG_WIDE  = 2;
    localparam int FLG_SUSP  = 3;
    localparam int FLG_SLEEP = 4;
    localparam int ST_BUSY   = 0;
    localparam int ST_WEL    = 1;
    localparam int CTRL_BUSY = 0;

    // Reset values and masks
    localparam logic [7:0] STATUS_RST     = 8'h00;
    localparam logic [7:0] CONFIG_RST     = 8'h00;
    localparam logic [7:0] EXT_ADDR_RST   = 8'h00;
    localparam logic [7:0] BURST_RST      = 8'h00;
    localparam logic [7:0] STATUS_WR_MASK = 8'hFC;
endpackage

// File: pkg/fsc_link_if.sv
// Signals between the link-clock shifter and the core-clock command decoder
`timescale 1ns/1ps
`default_nettype none
interface fsc_link_if;
    logic       byte_tgl;
    logic [1:0] byte_idx;
    logic [7:0] byte_val;
    logic       quad;
    logic       mute;
    logic [7:0] rd_status;
    logic [7:0] rd_cfg;
    logic [7:0] rd_ear;
    modport link (output byte_tgl, output byte_idx, output byte_val,
                  input quad, input mute, input rd_status, input rd_cfg, input rd_ear);
    modport core (input byte_tgl, input byte_idx, input byte_val,
                  output quad, output mute, output rd_status, output rd_cfg, output rd_ear);
endinterface
`default_nettype wire

// File: src/fsc_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module fsc_sync #(
    parameter logic RST = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } fsc_sync_s;

    fsc_sync_s r_q;
    fsc_sync_s r_d;

    always_comb begin
        r_d.meta   = d;
        r_d.stable = r_q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= {RST, RST};
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.stable;
endmodule
`default_nettype wire

// File: src/fsc_shifter.sv
// Link-clock shifter: collects bytes from the serial link and drives read data back
`timescale 1ns/1ps
`default_nettype none
module fsc_shifter (
    input  wire logic       link_clk,
    input  wire logic       resetn,
    input  wire logic       cs_n,
    input  wire logic [3:0] sio_in,
    output logic      [3:0] sio_out,
    output logic      [3:0] sio_oe,
    fsc_link_if.link        lk
);
    // Frame part: cleared by chip select, since the link clock stops between frames
    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [1:0] idx;
        logic       rd;
        logic [7:0] osh;
        logic [3:0] so;
        logic [3:0] soe;
    } fsc_frm_s;

    // Event part: must outlive the frame so the core can still see the last byte
    typedef struct packed {
        logic       tgl;
        logic [1:0] idx;
        logic [7:0] val;
    } fsc_evt_s;

    fsc_frm_s   f_q;
    fsc_frm_s   f_d;
    fsc_evt_s   e_q;
    fsc_evt_s   e_d;
    logic [2:0] step;
    logic [3:0] sum;
    logic [7:0] shifted;
    logic       frm_rst_n;

    function automatic logic [7:0] rot(input logic [7:0] v, input logic quad);
        return quad ? {v[3:0], v[7:4]} : {v[6:0], v[7]};
    endfunction

    function automatic logic [3:0] top(input logic [7:0] v, input logic quad);
        return quad ? v[7:4] : {2'h0, v[7], 1'h0};
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        return (op == fsc_pkg::OP_READ_STATUS) || (op == fsc_pkg::OP_READ_CONFIG) ||
               (op == fsc_pkg::OP_READ_EXT_ADDR);
    endfunction

    function automatic logic [7:0] pick(input logic [7:0] op);
        if (op == fsc_pkg::OP_READ_STATUS) begin
            return lk.rd_status;
        end else if (op == fsc_pkg::OP_READ_CONFIG) begin
            return lk.rd_cfg;
        end
        return lk.rd_ear;
    endfunction

    assign frm_rst_n = resetn & ~cs_n;

    always_comb begin
        f_d     = f_q;
        e_d     = e_q;
        step    = lk.quad ? fsc_pkg::QUAD_STEP : fsc_pkg::SINGLE_STEP;
        shifted = lk.quad ? {f_q.sh[3:0], sio_in} : {f_q.sh[6:0], sio_in[0]};
        sum     = {1'b0, f_q.cnt} + {1'b0, step};
        f_d.sh  = shifted;
        f_d.cnt = sum[2:0];
        // Read data repeats for as long as the host keeps clocking
        if (f_q.rd) begin
            f_d.osh = rot(f_q.osh, lk.quad);
            f_d.so  = top(f_d.osh, lk.quad);
        end
        if (sum == fsc_pkg::BYTE_BITS) begin
            if (f_q.idx != 2'h3) begin
                f_d.idx = f_q.idx + 2'h1;
            end
            e_d.tgl = ~e_q.tgl;
            e_d.idx = f_d.idx;
            e_d.val = shifted;
            if (f_q.idx == 2'h0 && is_read(shifted) && !lk.mute) begin
                f_d.rd  = 1'b1;
                f_d.osh = pick(shifted);
                f_d.so  = top(f_d.osh, lk.quad);
                f_d.soe = lk.quad ? fsc_pkg::OE_QUAD : fsc_pkg::OE_SINGLE;
            end
        end
    end

    always_ff @(posedge link_clk or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            e_q <= '0;
        end else begin
            e_q <= e_d;
        end
    end

    assign sio_out     = f_q.so;
    assign sio_oe      = f_q.soe;
    assign lk.byte_tgl = e_q.tgl;
    assign lk.byte_idx = e_q.idx;
    assign lk.byte_val = e_q.val;
endmodule
`default_nettype wire

// File: src/fsc_top.sv
// Flash setting command decoder: executes register and mode opcodes received over the serial link
//
// What this block does
// - Opcode 06 sets the write-enable latch, in single or quad mode.
// - Opcode 04 clears the write-enable latch, in either mode.
// - Opcode 05 drives the status register onto the data lines.
// - Opcode 15 drives the configuration register onto the data lines.
// - Opcode 01 takes one or two bytes: status, then optional configuration.
// - Opcode C8 drives the extended address register onto the data lines.
// - Opcode C5 takes exactly one byte into the extended address register.
// - Opcode 35 enters quad command mode, accepted only in single mode.
// - Opcode F5 returns to single mode, accepted only in quad mode.
// - Opcode B7 enters wide address mode and sets its indicator.
// - Opcode E9 leaves wide address mode and clears its indicator.
// - Opcode B0 suspends a program or erase in progress.
// - Opcode 30 resumes a suspended program or erase.
// - Opcode B9 enters deep sleep.
// - Opcode AB leaves deep sleep.
// - Opcode C0 updates the wrapped-read burst length.
// - Chip select frames each command; opcode takes 8 single or 2 quad clocks.
// - Status, configuration and extended address writes need the latch set.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fsc_top (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        link_clk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  sio_in,
    output logic      [3:0]  sio_out,
    output logic      [3:0]  sio_oe,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata
);
    typedef struct packed {
        logic        cs_q;
        logic        tgl_q;
        logic        have;
        logic [1:0]  nb;
        logic [7:0]  op;
        logic [7:0]  d1;
        logic [7:0]  d2;
        logic [7:0]  last;
        logic        write_enable_latch;
        logic        quad;
        logic        wide;
        logic        susp;
        logic        sleep;
        logic        busy;
        logic [7:0]  status;
        logic [7:0]  cfg;
        logic [7:0]  ear;
        logic [7:0]  burst;
        logic        sn_quad;
        logic        sn_mute;
        logic [7:0]  sn_st;
        logic [7:0]  sn_cfg;
        logic [7:0]  sn_ear;
        logic [31:0] rdata;
    } fsc_core_s;

    fsc_core_s  q;
    fsc_core_s  d;
    logic       cs_s;
    logic       tgl_s;
    logic       ev;
    logic       fend;
    logic       go;
    logic [7:0] gop;

    fsc_link_if lk ();

    fsc_sync #(
        .RST (1'b1)
    ) u_cs_sync (
        .clk   (core_clk),
        .rst_n (resetn),
        .d     (cs_n),
        .q     (cs_s)
    );

    fsc_sync #(
        .RST (1'b0)
    ) u_tgl_sync (
        .clk   (core_clk),
        .rst_n (resetn),
        .d     (lk.byte_tgl),
        .q     (tgl_s)
    );

    fsc_shifter u_shifter (
        .link_clk (link_clk),
        .resetn   (resetn),
        .cs_n     (cs_n),
        .sio_in   (sio_in),
        .sio_out  (sio_out),
        .sio_oe   (sio_oe),
        .lk       (lk.link)
    );

    // Status as the host and software see it: busy and latch are live bits
    function automatic logic [7:0] status_of(input fsc_core_s s);
        logic [7:0] v;
        v                    = s.status;
        v[fsc_pkg::ST_BUSY]  = s.busy & ~s.susp;
        v[fsc_pkg::ST_WEL]   = s.write_enable_latch;
        return v;
    endfunction

    always_comb begin
        d       = q;
        ev      = tgl_s != q.tgl_q;
        fend    = cs_s & ~q.cs_q;
        d.cs_q  = cs_s;
        d.tgl_q = tgl_s;
        // Byte index and value were settled before the toggle got through its synchroniser
        if (ev) begin
            if (lk.byte_idx == 2'h1) begin
                d.op   = lk.byte_val;
                d.have = 1'b1;
                d.nb   = 2'h0;
            end else if (lk.byte_idx != 2'h0) begin
                if (q.nb == 2'h0) begin
                    d.d1 = lk.byte_val;
                end else if (q.nb == 2'h1) begin
                    d.d2 = lk.byte_val;
                end
                if (q.nb != 2'h3) begin
                    d.nb = q.nb + 2'h1;
                end
            end
        end
        // Commands take effect when the frame closes, so a frame cut short before its opcode byte completes does nothing
        go  = fend & d.have;
        gop = d.op;
        if (go) begin
            d.have = 1'b0;
            d.last = d.op;
            if (q.sleep) begin
                if (d.op == fsc_pkg::OP_WAKE_FROM_SLEEP) begin
                    d.sleep = 1'b0;
                end
            end else begin
                case (d.op)
                    fsc_pkg::OP_WRITE_ENABLE: begin
                        d.write_enable_latch = 1'b1;
                    end
                    fsc_pkg::OP_WRITE_DISABLE: begin
                        d.write_enable_latch = 1'b0;
                    end
                    fsc_pkg::OP_WRITE_STATUS_CONFIG: begin
                        if (d.write_enable_latch && (d.nb == 2'h1 || d.nb == 2'h2)) begin
                            d.status = (d.d1 & fsc_pkg::STATUS_WR_MASK) |
                                       (q.status & ~fsc_pkg::STATUS_WR_MASK);
                            if (d.nb == 2'h2) begin
                                d.cfg = d.d2;
                            end
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    fsc_pkg::OP_WRITE_EXT_ADDR: begin
                        if (d.write_enable_latch && d.nb == 2'h1) begin
                            d.ear = d.d1;
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    fsc_pkg::OP_ENTER_QUAD: begin
                        if (!q.quad) begin
                            d.quad = 1'b1;
                        end
                    end
                    fsc_pkg::OP_EXIT_QUAD: begin
                        if (q.quad) begin
                            d.quad = 1'b0;
                        end
                    end
                    fsc_pkg::OP_ENTER_WIDE_ADDR: begin
                        d.wide = 1'b1;
                    end
                    fsc_pkg::OP_EXIT_WIDE_ADDR: begin
                        d.wide = 1'b0;
                    end
                    fsc_pkg::OP_SUSPEND: begin
                        if (q.busy) begin
                            d.susp = 1'b1;
                        end
                    end
                    fsc_pkg::OP_RESUME: begin
                        d.susp = 1'b0;
                    end
                    fsc_pkg::OP_DEEP_SLEEP: begin
                        d.sleep = 1'b1;
                    end
                    fsc_pkg::OP_BURST_LENGTH: begin
                        if (d.nb != 2'h0) begin
                            d.burst = d.d1;
                        end
                    end
                    default: begin
                        d.last = q.last;
                    end
                endcase
            end
        end
        if (reg_wr && reg_addr == fsc_pkg::REG_CTRL) begin
            d.busy = reg_wdata[fsc_pkg::CTRL_BUSY];
        end
        // Ending the operation also ends its suspension
        d.susp = d.susp & d.busy;
        // The link reads these without a synchroniser, so they only move between frames
        if (cs_s) begin
            d.sn_quad = d.quad;
            d.sn_mute = d.sleep;
            d.sn_st   = status_of(d);
            d.sn_cfg  = d.cfg;
            d.sn_ear  = d.ear;
        end
        d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                fsc_pkg::REG_FLAGS: begin
                    d.rdata[fsc_pkg::FLG_WEL]   = q.write_enable_latch;
                    d.rdata[fsc_pkg::FLG_QUAD]  = q.quad;
                    d.rdata[fsc_pkg::FLG_WIDE]  = q.wide;
                    d.rdata[fsc_pkg::FLG_SUSP]  = q.susp;
                    d.rdata[fsc_pkg::FLG_SLEEP] = q.sleep;
                end
                fsc_pkg::REG_STATUS: begin
                    d.rdata[7:0] = status_of(q);
                end
                fsc_pkg::REG_CONFIG: begin
                    d.rdata[7:0] = q.cfg;
                end
                fsc_pkg::REG_EXT_ADDR: begin
                    d.rdata[7:0] = q.ear;
                end
                fsc_pkg::REG_BURST: begin
                    d.rdata[7:0] = q.burst;
                end
                fsc_pkg::REG_CTRL: begin
                    d.rdata[fsc_pkg::CTRL_BUSY] = q.busy;
                end
                fsc_pkg::REG_LAST_OP: begin
                    d.rdata[7:0] = q.last;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q        <= '0;
            q.cs_q   <= 1'b1;
            q.status <= fsc_pkg::STATUS_RST;
            q.cfg    <= fsc_pkg::CONFIG_RST;
            q.ear    <= fsc_pkg::EXT_ADDR_RST;
            q.burst  <= fsc_pkg::BURST_RST;
            q.sn_cfg <= fsc_pkg::CONFIG_RST;
            q.sn_ear <= fsc_pkg::EXT_ADDR_RST;
        end else begin
            q <= d;
        end
    end

    assign lk.quad      = q.sn_quad;
    assign lk.mute      = q.sn_mute;
    assign lk.rd_status = q.sn_st;
    assign lk.rd_cfg    = q.sn_cfg;
    assign lk.rd_ear    = q.sn_ear;
    assign reg_rdata    = q.rdata;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_cmd(logic [7:0] o);
        go && gop == o && !q.sleep;
    endsequence

    property p_wel_set;
        s_cmd(fsc_pkg::OP_WRITE_ENABLE) |=> q.write_enable_latch ##[0:2] lk.rd_status[fsc_pkg::ST_WEL];
    endproperty
    a_wel_set: assert property (p_wel_set)
        else $error("write enable did not set the latch");

    property p_wel_clr;
        s_cmd(fsc_pkg::OP_WRITE_DISABLE) ##0 !reg_wr |=> !q.write_enable_latch;
    endproperty
    a_wel_clr: assert property (p_wel_clr)
        else $error("write disable did not clear the latch");

    property p_stat_load;
        // The latch before the command decides; the next state has it cleared already
        s_cmd(fsc_pkg::OP_WRITE_STATUS_CONFIG) ##0 (q.write_enable_latch && d.nb == 2'h2)
            |=> q.status[7:2] == $past(d.d1[7:2]) && q.cfg == $past(d.d2) && !q.write_enable_latch;
    endproperty
    a_stat_load: assert property (p_stat_load)
        else $error("status write did not load both bytes");

    property p_stat_locked;
        s_cmd(fsc_pkg::OP_WRITE_STATUS_CONFIG) ##0 !q.write_enable_latch |=> $stable(q.status) && $stable(q.cfg);
    endproperty
    a_stat_locked: assert property (p_stat_locked)
        else $error("status changed without write enable");

    property p_ext_load;
        s_cmd(fsc_pkg::OP_WRITE_EXT_ADDR) ##0 (q.write_enable_latch && d.nb == 2'h1) |=> q.ear == $past(d.d1);
    endproperty
    a_ext_load: assert property (p_ext_load)
        else $error("extended address not loaded");

    property p_quad_in;
        s_cmd(fsc_pkg::OP_ENTER_QUAD) ##0 !q.quad |=> q.quad ##[0:2] lk.quad;
    endproperty
    a_quad_in: assert property (p_quad_in)
        else $error("quad mode not entered");

    property p_quad_out;
        s_cmd(fsc_pkg::OP_EXIT_QUAD) ##0 q.quad |=> !q.quad;
    endproperty
    a_quad_out: assert property (p_quad_out)
        else $error("quad mode not left");

    property p_wide_in;
        s_cmd(fsc_pkg::OP_ENTER_WIDE_ADDR) |=> q.wide [*2];
    endproperty
    a_wide_in: assert property (p_wide_in)
        else $error("wide address mode not entered");

    property p_wide_out;
        s_cmd(fsc_pkg::OP_EXIT_WIDE_ADDR) |=> !q.wide [*2];
    endproperty
    a_wide_out: assert property (p_wide_out)
        else $error("wide address mode not left");

    property p_suspend;
        s_cmd(fsc_pkg::OP_SUSPEND) ##0 (q.busy && !reg_wr) |=> q.susp && !lk.rd_status[fsc_pkg::ST_BUSY];
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend not taken");

    property p_resume;
        s_cmd(fsc_pkg::OP_RESUME) |=> !q.susp;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume not taken");

    property p_sleep;
        s_cmd(fsc_pkg::OP_DEEP_SLEEP) |=> q.sleep ##[0:2] lk.mute;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("deep sleep not entered");

    property p_wake;
        go && gop == fsc_pkg::OP_WAKE_FROM_SLEEP && q.sleep |=> !q.sleep;
    endproperty
    a_wake: assert property (p_wake)
        else $error("deep sleep not left");

    property p_burst;
        s_cmd(fsc_pkg::OP_BURST_LENGTH) ##0 d.nb != 2'h0 |=> q.burst == $past(d.d1);
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst length not updated");

    property p_sleep_ignores;
        go && q.sleep && gop != fsc_pkg::OP_WAKE_FROM_SLEEP && !reg_wr
            |=> $stable(q.write_enable_latch) && $stable(q.quad) && $stable(q.wide) && $stable(q.status);
    endproperty
    a_sleep_ignores: assert property (p_sleep_ignores)
        else $error("command acted during deep sleep");
endmodule
`default_nettype wire

// File: test/fsc_host_model.sv
// Host controller model: frames commands on the serial link and captures read data
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
    output logic            link_clk,
    output logic            cs_n,
    output logic      [3:0] sio_in,
    input  wire logic [3:0] sio_out
);
    initial begin
        link_clk = 1'b0;
        cs_n     = 1'b1;
        sio_in   = 4'h0;
    end

    // Clock stands still between frames; idle lines toggle so stale bits cannot pass for data
    task automatic frame(input logic [23:0] b, input int nb, input bit q, input bit rd, output logic [7:0] got);
        int n;
        n   = q ? 2 : 8;
        got = 8'h00;
        #7 cs_n = 1'b0;
        for (int i = 0; i < (nb + rd) * n; i++) begin
            if (i < nb * n)
                sio_in = q ? b[23 - 4 * i -: 4] : {~sio_in[3:1], b[23 - i]};
            else
                sio_in = ~sio_in;
            #24;
            // Sample just before the edge, while the previous edge's output is settled
            if (rd && i >= n)
                got = q ? {got[3:0], sio_out} : {got[6:0], sio_out[1]};
            link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
        #10 cs_n = 1'b1;
        sio_in = ~sio_in;
        // Gap far above the minimum so the core has synchronised the command
        #200;
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Testbench: register reads and link frames through the host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    logic        core_clk  = 1'b0;
    logic        resetn    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        link_clk;
    logic        cs_n;
    logic [3:0]  sio_in;
    logic [3:0]  sio_out;
    logic [3:0]  sio_oe;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic [3:0]  oe_seen = 4'h0;
    int          err_count = 0;
    int          n_checks  = 0;
    int          cyc       = 0;

    always #10 core_clk = ~core_clk;

    // Drive enable at the last link edge of a frame; the link clock stops once cs_n rises
    always @(negedge link_clk) oe_seen <= sio_oe;

    fsc_top uut (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .link_clk  (link_clk),
        .cs_n      (cs_n),
        .sio_in    (sio_in),
        .sio_out   (sio_out),
        .sio_oe    (sio_oe),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    fsc_host_model host (
        .link_clk (link_clk),
        .cs_n     (cs_n),
        .sio_in   (sio_in),
        .sio_out  (sio_out)
    );

    task automatic end_of_test();
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Send one command frame, then read back one register
    task automatic fx(input logic [23:0] b, input int nb, input bit q, input logic [7:0] a, input logic [31:0] e);
        logic [7:0]  g;
        logic [31:0] v;
        host.frame(b, nb, q, 1'b0, g);
        reg_read(a, v);
        `CHK("register", e, v)
    endtask

    // Send a read opcode and compare the byte returned on the link
    task automatic rx(input logic [7:0] op, input bit q, input logic [7:0] e, input logic [3:0] eo);
        logic [7:0] g;
        host.frame({op, 16'h0000}, 1, q, 1'b1, g);
        `CHK("link read", e, g)
        `CHK("link oe", eo, oe_seen)
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        reg_read(fsc_pkg::REG_FLAGS, d);
        `CHK("flags after reset", 32'h0, d)
        reg_read(8'h1C, d);
        `CHK("unmapped", 32'h0, d)
        fx({fsc_pkg::OP_WRITE_STATUS_CONFIG, 16'hA45A}, 3, 0, fsc_pkg::REG_STATUS, 32'h0);
        fx({fsc_pkg::OP_WRITE_ENABLE, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h1);
        fx({fsc_pkg::OP_WRITE_DISABLE, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h0);
        fx({fsc_pkg::OP_WRITE_ENABLE, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h1);
        fx({fsc_pkg::OP_WRITE_STATUS_CONFIG, 16'hA45A}, 3, 0, fsc_pkg::REG_STATUS, 32'hA4);
        reg_read(fsc_pkg::REG_CONFIG, d);
        `CHK("config", 32'h5A, d)
        fx({fsc_pkg::OP_WRITE_ENABLE, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h1);
        fx({fsc_pkg::OP_WRITE_EXT_ADDR, 16'h3C00}, 2, 0, fsc_pkg::REG_EXT_ADDR, 32'h3C);
        rx(fsc_pkg::OP_READ_STATUS, 0, 8'hA4, fsc_pkg::OE_SINGLE);
        rx(fsc_pkg::OP_READ_CONFIG, 0, 8'h5A, fsc_pkg::OE_SINGLE);
        rx(fsc_pkg::OP_READ_EXT_ADDR, 0, 8'h3C, fsc_pkg::OE_SINGLE);
        fx({fsc_pkg::OP_EXIT_QUAD, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h0);
        fx({fsc_pkg::OP_ENTER_QUAD, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h2);
        fx({fsc_pkg::OP_WRITE_ENABLE, 16'h0}, 1, 1, fsc_pkg::REG_FLAGS, 32'h3);
        rx(fsc_pkg::OP_READ_STATUS, 1, 8'hA6, fsc_pkg::OE_QUAD);
        fx({fsc_pkg::OP_EXIT_QUAD, 16'h0}, 1, 1, fsc_pkg::REG_FLAGS, 32'h1);
        fx({fsc_pkg::OP_ENTER_WIDE_ADDR, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h5);
        fx({fsc_pkg::OP_EXIT_WIDE_ADDR, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h1);
        reg_write(fsc_pkg::REG_CTRL, 32'h1);
        fx({fsc_pkg::OP_SUSPEND, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h9);
        fx({fsc_pkg::OP_RESUME, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h1);
        reg_write(fsc_pkg::REG_CTRL, 32'h0);
        fx({fsc_pkg::OP_BURST_LENGTH, 16'h0700}, 2, 0, fsc_pkg::REG_BURST, 32'h07);
        fx({fsc_pkg::OP_DEEP_SLEEP, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h11);
        fx({fsc_pkg::OP_WRITE_DISABLE, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h11);
        rx(fsc_pkg::OP_READ_STATUS, 0, 8'h00, 4'h0);
        fx({fsc_pkg::OP_WAKE_FROM_SLEEP, 16'h0}, 1, 0, fsc_pkg::REG_FLAGS, 32'h1);
        fx({8'h77, 16'h0}, 1, 0, fsc_pkg::REG_LAST_OP, 32'hAB);
        end_of_test();
    end
endmodule
`default_nettype wire
